// *** core/mmel_top.sv ***
// Monitor-mode entry decode, clock and watchdog control, and host link sequencing
`timescale 1ns/10ps
module mmel_top #(
  parameter int unsigned BIT_CYC = mmel_pkg::BIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  input wire logic entry_tst,
  input wire logic reset_tst,
  input wire logic entry_pin_low,
  input wire logic vector_blank,
  input wire logic divider_select_pin,
  input wire logic entry_select_pin_b,
  input wire logic entry_select_pin_c,
  input wire logic monitor_serial_pin_i,
  output logic monitor_serial_pin_o,
  output logic monitor_serial_pin_oe,
  output logic monitor_mode_q,
  output logic tst_entry_q,
  output logic serial_style_q,
  output logic core_clock_bypass_q,
  output logic div4_q,
  output logic bus_clk_q,
  output logic pll_enable_q,
  output logic watchdog_disable_q,
  output logic [15:0] reset_vector_q,
  output logic [15:0] swi_vector_q,
  output logic security_done_q,
  output logic cmd_valid_q,
  output logic [7:0] cmd_byte_q
);
  localparam logic [3:0] SEC_LAST = 4'(mmel_pkg::SEC_BYTES - 1);
  localparam logic [3:0] SEC_FULL = 4'(mmel_pkg::SEC_BYTES);

  typedef enum logic [1:0] {fl_off, fl_secure, fl_brk, fl_cmd} mmel_flow_t;

  logic [mmel_pkg::NPINS-1:0] pins;
  logic [mmel_pkg::NPINS-1:0] pin_m_q;
  logic [mmel_pkg::NPINS-1:0] pin_s_q;
  logic rpin_s;
  logic etst_s;
  logic rtst_s;
  logic elow_s;
  logic div_s;
  logic selb_s;
  logic selc_s;
  logic ser_s;
  logic rpin_prev_q;
  logic rpin_rise;
  logic tst_ok;
  logic blank_mon;
  logic [1:0] div_cnt_q;
  mmel_flow_t fl_q;
  logic [3:0] sec_cnt_q;
  logic tx_req_q;
  logic [7:0] tx_byte_q;
  logic tx_brk_q;
  logic tx_lead_q;

  mmel_link_if lk_if ();

  assign pins = {monitor_serial_pin_i, entry_select_pin_c, entry_select_pin_b, divider_select_pin,
                 entry_pin_low, reset_tst, entry_tst, reset_pin_n};

  // Every pin input passes two flops before any logic sees it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else begin
      pin_m_q <= pins;
      pin_s_q <= pin_m_q;
    end
  end

  assign rpin_s = pin_s_q[mmel_pkg::P_RST];
  assign etst_s = pin_s_q[mmel_pkg::P_ETST];
  assign rtst_s = pin_s_q[mmel_pkg::P_RTST];
  assign elow_s = pin_s_q[mmel_pkg::P_ELOW];
  assign div_s = pin_s_q[mmel_pkg::P_DIV];
  assign selb_s = pin_s_q[mmel_pkg::P_SELB];
  assign selc_s = pin_s_q[mmel_pkg::P_SELC];
  assign ser_s = pin_s_q[mmel_pkg::P_SER];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rpin_prev_q <= 1'b0;
    end else begin
      rpin_prev_q <= rpin_s;
    end
  end

  assign rpin_rise = rpin_s && !rpin_prev_q;
  // Select pins only count when the test voltage is present
  assign tst_ok = etst_s && selb_s && !selc_s;
  assign blank_mon = monitor_mode_q && !tst_entry_q;

  // Entry conditions are sampled once, on the reset pin rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      monitor_mode_q <= 1'b0;
      tst_entry_q <= 1'b0;
      core_clock_bypass_q <= 1'b0;
      div4_q <= 1'b1;
      pll_enable_q <= 1'b0;
      serial_style_q <= 1'b1;
    end else if (rpin_rise && !blank_mon) begin
      if (tst_ok) begin
        monitor_mode_q <= 1'b1;
        tst_entry_q <= 1'b1;
        core_clock_bypass_q <= !div_s;
        div4_q <= div_s;
        pll_enable_q <= 1'b0;
        serial_style_q <= ser_s;
      end else if (vector_blank) begin
        monitor_mode_q <= 1'b1;
        tst_entry_q <= 1'b0;
        core_clock_bypass_q <= 1'b0;
        div4_q <= 1'b1;
        pll_enable_q <= elow_s;
        serial_style_q <= 1'b1;
      end else begin
        monitor_mode_q <= 1'b0;
        tst_entry_q <= 1'b0;
        core_clock_bypass_q <= 1'b0;
        div4_q <= 1'b1;
        pll_enable_q <= 1'b0;
        serial_style_q <= 1'b1;
      end
    end
  end

  // Bus clock stands still while the reset pin is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= '0;
      bus_clk_q <= 1'b0;
    end else if (!rpin_s) begin
      div_cnt_q <= '0;
      bus_clk_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
      bus_clk_q <= div4_q ? div_cnt_q[1] : div_cnt_q[0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_disable_q <= 1'b1;
    end else begin
      watchdog_disable_q <= !rpin_s
                            || blank_mon
                            || (monitor_mode_q && tst_entry_q && (etst_s || rtst_s));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_vector_q <= mmel_pkg::VEC_RST_USR;
      swi_vector_q <= mmel_pkg::VEC_SWI_USR;
    end else begin
      reset_vector_q <= monitor_mode_q ? mmel_pkg::VEC_RST_MON : mmel_pkg::VEC_RST_USR;
      swi_vector_q <= monitor_mode_q ? mmel_pkg::VEC_SWI_MON : mmel_pkg::VEC_SWI_USR;
    end
  end

  // Link sequencing: security bytes, ready break, then command bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fl_q <= fl_off;
      sec_cnt_q <= '0;
      security_done_q <= 1'b0;
      tx_req_q <= 1'b0;
      tx_byte_q <= '0;
      tx_brk_q <= 1'b0;
      tx_lead_q <= 1'b0;
      cmd_valid_q <= 1'b0;
      cmd_byte_q <= '0;
    end else begin
      tx_req_q <= 1'b0;
      cmd_valid_q <= 1'b0;
      if (!rpin_s) begin
        fl_q <= fl_off;
        sec_cnt_q <= '0;
        security_done_q <= 1'b0;
      end else begin
        case (fl_q)
          fl_off: begin
            if (monitor_mode_q && serial_style_q && !rpin_rise) begin
              fl_q <= fl_secure;
            end
          end
          fl_secure, fl_cmd: begin
            if (lk_if.rx_brk) begin
              tx_req_q <= 1'b1;
              tx_brk_q <= 1'b1;
              tx_lead_q <= 1'b1;
            end else if (lk_if.rx_valid) begin
              tx_req_q <= 1'b1;
              tx_byte_q <= lk_if.rx_byte;
              tx_brk_q <= 1'b0;
              tx_lead_q <= 1'b0;
              if (fl_q == fl_cmd) begin
                cmd_valid_q <= 1'b1;
                cmd_byte_q <= lk_if.rx_byte;
              end else begin
                sec_cnt_q <= sec_cnt_q + 1'b1;
                if (sec_cnt_q == SEC_LAST) begin
                  fl_q <= fl_brk;
                end
              end
            end
          end
          fl_brk: begin
            // Let the echo of the last security byte finish first
            if (!lk_if.tx_busy && !tx_req_q) begin
              tx_req_q <= 1'b1;
              tx_brk_q <= 1'b1;
              tx_lead_q <= 1'b0;
              security_done_q <= 1'b1;
              fl_q <= fl_cmd;
            end
          end
          default: fl_q <= fl_off;
        endcase
      end
    end
  end

  assign lk_if.en = fl_q != fl_off;
  assign lk_if.tx_req = tx_req_q;
  assign lk_if.tx_byte = tx_byte_q;
  assign lk_if.tx_brk = tx_brk_q;
  assign lk_if.tx_lead = tx_lead_q;

  mmel_link #(
    .BIT_CYC(BIT_CYC)
  ) u_link (
    .clk(clk),
    .rst_n(rst_n),
    .lk(lk_if.link),
    .ser_in(ser_s),
    .ser_out(monitor_serial_pin_o),
    .ser_oe(monitor_serial_pin_oe)
  );

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_half_bus_clk: assert property (
    (rpin_s && tst_entry_q && !div4_q) [*3] |-> bus_clk_q != $past(bus_clk_q))
    else $error("bus clock not at half input rate");
  chk_quarter_bus_clk: assert property (
    (rpin_s && div4_q) [*6] |-> bus_clk_q == $past(bus_clk_q, 4) && bus_clk_q != $past(bus_clk_q, 2))
    else $error("bus clock not at quarter input rate");
  chk_bypass_tst_only: assert property (core_clock_bypass_q |-> tst_entry_q && !div4_q)
    else $error("oscillator bypass without test-voltage entry");
  chk_blank_ignore_pins: assert property (blank_mon |-> div4_q && !core_clock_bypass_q)
    else $error("divider pin honoured on blank-vector entry");
  chk_reset_no_op: assert property (!rpin_s |=> watchdog_disable_q && !bus_clk_q && fl_q == fl_off)
    else $error("activity while reset pin is low");
  chk_blank_watchdog: assert property (blank_mon |=> watchdog_disable_q)
    else $error("watchdog enabled in blank-vector monitor mode");
  chk_tst_watchdog: assert property (
    rpin_s && monitor_mode_q && tst_entry_q && !etst_s && !rtst_s |=> !watchdog_disable_q)
    else $error("watchdog kept off after test voltage removed");
  chk_latch_on_edge: assert property (!rpin_rise |=> $stable(monitor_mode_q) && $stable(tst_entry_q))
    else $error("mode changed away from reset rising edge");
  chk_security_count: assert property ($rose(security_done_q) |-> sec_cnt_q == SEC_FULL)
    else $error("ready break sent before eight security bytes");
  chk_ready_break: assert property ($rose(security_done_q) |-> tx_req_q && tx_brk_q && !tx_lead_q)
    else $error("no break sent after security");
  chk_vector_page: assert property (
    monitor_mode_q && $stable(monitor_mode_q) |-> reset_vector_q == mmel_pkg::VEC_RST_MON
                                                   && swi_vector_q == mmel_pkg::VEC_SWI_MON)
    else $error("monitor vectors not on alternate page");
  chk_blank_sticky: assert property (blank_mon |=> monitor_mode_q && !tst_entry_q)
    else $error("blank-vector monitor mode left without power-on reset");
  chk_break_echo: assert property (fl_q != fl_off && rpin_s && lk_if.rx_brk |=> tx_req_q && tx_brk_q && tx_lead_q)
    else $error("received break not echoed with high lead-in");
  chk_pll_select: assert property (pll_enable_q |-> blank_mon)
    else $error("phase-locked loop enabled outside blank-vector entry");
  chk_byte_echo: assert property (
    fl_q != fl_off && rpin_s && lk_if.rx_valid && !lk_if.rx_brk |=> tx_req_q && tx_byte_q == $past(lk_if.rx_byte))
    else $error("received byte not echoed");

  cov_tst_half: cover property (rpin_rise ##1 tst_entry_q && core_clock_bypass_q);
  cov_blank_pll: cover property (rpin_rise ##1 blank_mon && pll_enable_q);
  cov_security_done: cover property ($rose(security_done_q));
  cov_break_echo: cover property (fl_q == fl_cmd && lk_if.rx_brk);
endmodule // mmel_top

// *** core/mmel_pkg.sv ***
// Shared constants for the monitor-mode entry and serial link block
package mmel_pkg;
  // Core clock and link bit rate
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  // Character framing
  localparam int unsigned GAP_BITS = 2;
  localparam int unsigned FRAME_BITS = 10;
  localparam int unsigned BRK_BITS = 10;
  localparam int unsigned SEC_BYTES = 8;
  // Vector fetch addresses
  localparam logic [15:0] VEC_RST_MON = 16'hFEFE;
  localparam logic [15:0] VEC_RST_USR = 16'hFFFE;
  localparam logic [15:0] VEC_SWI_MON = 16'hFEFC;
  localparam logic [15:0] VEC_SWI_USR = 16'hFFFC;
  // Positions in the synchronised pin vector
  localparam int unsigned P_RST = 0;
  localparam int unsigned P_ETST = 1;
  localparam int unsigned P_RTST = 2;
  localparam int unsigned P_ELOW = 3;
  localparam int unsigned P_DIV = 4;
  localparam int unsigned P_SELB = 5;
  localparam int unsigned P_SELC = 6;
  localparam int unsigned P_SER = 7;
  localparam int unsigned NPINS = 8;
endpackage

// *** core/mmel_link_if.sv ***
// Carrier between the entry controller and the serial bit engine
`timescale 1ns/10ps
interface mmel_link_if;
  logic en;
  logic tx_req;
  logic [7:0] tx_byte;
  logic tx_brk;
  logic tx_lead;
  logic tx_busy;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic rx_brk;
  modport ctrl (output en, output tx_req, output tx_byte, output tx_brk, output tx_lead,
                input tx_busy, input rx_valid, input rx_byte, input rx_brk);
  modport link (input en, input tx_req, input tx_byte, input tx_brk, input tx_lead,
                output tx_busy, output rx_valid, output rx_byte, output rx_brk);
endinterface // mmel_link_if

// *** core/mmel_link.sv ***
// Serial bit engine for the single-wire monitor link
`timescale 1ns/10ps
module mmel_link #(
  parameter int unsigned BIT_CYC = mmel_pkg::BIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  mmel_link_if.link lk,
  input wire logic ser_in,
  output logic ser_out,
  output logic ser_oe
);
  localparam int unsigned CW = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] BIT_HALF = CW'(BIT_CYC / 2);
  localparam logic [3:0] GAP_LAST = 4'(mmel_pkg::GAP_BITS - 1);
  localparam logic [3:0] FRM_LAST = 4'(mmel_pkg::FRAME_BITS - 1);

  typedef enum logic [1:0] {rx_idle, rx_bits, rx_wait_high} mmel_rx_t;
  typedef enum logic [1:0] {tx_idle, tx_gap, tx_bits} mmel_tx_t;

  mmel_rx_t rx_q;
  logic [CW-1:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  mmel_tx_t tx_q;
  logic [CW-1:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [9:0] tx_sh_q;
  logic tx_lead_q;
  logic rx_tick;
  logic tx_tick;

  // One bit period serves both directions
  assign rx_tick = rx_cnt_q == '0;
  assign tx_tick = tx_cnt_q == '0;
  assign lk.tx_busy = tx_q != tx_idle;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= rx_idle;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
    end else begin
      case (rx_q)
        rx_idle: begin
          // Own output returns on the shared wire, so listen only while quiet
          if (lk.en && !lk.tx_busy && !ser_in) begin
            rx_q <= rx_bits;
            rx_cnt_q <= BIT_HALF;
            rx_bit_q <= '0;
          end
        end
        rx_bits: begin
          if (!rx_tick) begin
            rx_cnt_q <= rx_cnt_q - 1'b1;
          end else begin
            rx_cnt_q <= BIT_LAST;
            rx_bit_q <= rx_bit_q + 1'b1;
            if (rx_bit_q == '0 && ser_in) begin
              rx_q <= rx_idle;
            end else if (rx_bit_q == FRM_LAST) begin
              rx_q <= rx_wait_high;
            end else if (rx_bit_q != '0) begin
              rx_sh_q <= {ser_in, rx_sh_q[7:1]};
            end
          end
        end
        rx_wait_high: begin
          if (ser_in) begin
            rx_q <= rx_idle;
          end
        end
        default: rx_q <= rx_idle;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lk.rx_valid <= 1'b0;
      lk.rx_brk <= 1'b0;
      lk.rx_byte <= '0;
    end else begin
      lk.rx_valid <= 1'b0;
      lk.rx_brk <= 1'b0;
      if (rx_q == rx_bits && rx_tick && rx_bit_q == FRM_LAST) begin
        if (ser_in) begin
          lk.rx_valid <= 1'b1;
          lk.rx_byte <= rx_sh_q;
        end else if (rx_sh_q == '0) begin
          lk.rx_brk <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= tx_idle;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= '0;
      tx_lead_q <= 1'b0;
    end else begin
      case (tx_q)
        tx_idle: begin
          if (lk.tx_req) begin
            tx_q <= tx_gap;
            tx_cnt_q <= BIT_LAST;
            tx_bit_q <= '0;
            tx_lead_q <= lk.tx_lead;
            tx_sh_q <= lk.tx_brk ? '0 : {1'b1, lk.tx_byte, 1'b0};
          end
        end
        tx_gap: begin
          if (!tx_tick) begin
            tx_cnt_q <= tx_cnt_q - 1'b1;
          end else begin
            tx_cnt_q <= BIT_LAST;
            tx_bit_q <= (tx_bit_q == GAP_LAST) ? '0 : tx_bit_q + 1'b1;
            if (tx_bit_q == GAP_LAST) begin
              tx_q <= tx_bits;
            end
          end
        end
        tx_bits: begin
          if (!tx_tick) begin
            tx_cnt_q <= tx_cnt_q - 1'b1;
          end else begin
            tx_cnt_q <= BIT_LAST;
            tx_bit_q <= tx_bit_q + 1'b1;
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            if (tx_bit_q == FRM_LAST) begin
              tx_q <= tx_idle;
            end
          end
        end
        default: tx_q <= tx_idle;
      endcase
    end
  end

  // Ones are left to the pullup; only the lead-in before a break echo drives high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_out <= 1'b0;
      ser_oe <= 1'b0;
    end else begin
      ser_out <= tx_q == tx_gap;
      ser_oe <= (tx_q == tx_gap && tx_lead_q) || (tx_q == tx_bits && !tx_sh_q[0]);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_drive_high_lead: assert property (ser_oe && ser_out |-> $past(tx_q == tx_gap && tx_lead_q))
    else $error("serial pin driven high outside break lead-in");
  chk_start_bit_low: assert property ($rose(tx_q == tx_bits) |=> ser_oe && !ser_out)
    else $error("frame does not open with a low start bit");
endmodule // mmel_link

// *** test/mmel_host.sv ***
// Host-side model of the single-wire monitor link
`timescale 1ns/10ps
module mmel_host #(
  parameter int unsigned BIT_CYC = 16
) (
  input wire logic clk,
  input wire logic line,
  output logic pull_low
);
  initial pull_low = 1'b0;
  // Host only ever pulls low; high comes from the pull-up
  task automatic hold_bits(input logic lvl, input int n);
    repeat (n * BIT_CYC) @(negedge clk) pull_low = !lvl;
  endtask
  task automatic send_byte(input logic [7:0] b);
    hold_bits(1'b0, 1);
    for (int i = 0; i < 8; i++) begin
      hold_bits(b[i], 1);
    end
    hold_bits(1'b1, 1);
  endtask
  task automatic send_break();
    hold_bits(1'b0, 10);
    @(negedge clk) pull_low = 1'b0;
  endtask
  // Samples at the falling edge so device updates have settled
  task automatic recv(output logic [7:0] b, output logic stop, output logic got);
    int n;
    n = 0;
    b = 8'h00;
    stop = 1'b0;
    while (line !== 1'b0 && n < 40 * BIT_CYC) begin
      @(negedge clk);
      n++;
    end
    got = (line === 1'b0);
    repeat (BIT_CYC / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(negedge clk);
      b[i] = line;
    end
    repeat (BIT_CYC) @(negedge clk);
    stop = line;
  endtask
endmodule // mmel_host

// *** test/tb_mmel_top.sv ***
// Self-checking bench for monitor-mode entry and the serial link
`timescale 1ns/10ps
module tb_mmel_top;
  localparam int unsigned BC = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin_n = 1'b0;
  logic entry_tst = 1'b0;
  logic reset_tst = 1'b0;
  logic entry_pin_low = 1'b0;
  logic vector_blank = 1'b0;
  logic div_pin = 1'b0;
  logic sel_b = 1'b1;
  logic sel_c = 1'b0;
  logic par_low = 1'b0;
  logic pull_low, line, ser_o, ser_oe, mon, tst, style, byp, div4, bclk, pll, wd, sec, cmd_v;
  logic [15:0] rvec, svec;
  logic [7:0] cmd_b;
  logic [7:0] last_cmd = 8'h00;
  int n_errors = 0;
  int checks = 0;
  int n_cmd = 0;
  int cyc = 0;
  always #50 clk = !clk;
  // Pull-up wins unless someone pulls low
  assign line = ((ser_oe & !ser_o) | pull_low | par_low) ? 1'b0 : 1'b1;
  mmel_top #(.BIT_CYC(BC)) mmel_top_inst (.clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
    .entry_tst(entry_tst), .reset_tst(reset_tst), .entry_pin_low(entry_pin_low), .vector_blank(vector_blank),
    .divider_select_pin(div_pin), .entry_select_pin_b(sel_b), .entry_select_pin_c(sel_c),
    .monitor_serial_pin_i(line), .monitor_serial_pin_o(ser_o), .monitor_serial_pin_oe(ser_oe),
    .monitor_mode_q(mon), .tst_entry_q(tst), .serial_style_q(style), .core_clock_bypass_q(byp), .div4_q(div4),
    .bus_clk_q(bclk), .pll_enable_q(pll), .watchdog_disable_q(wd), .reset_vector_q(rvec), .swi_vector_q(svec),
    .security_done_q(sec), .cmd_valid_q(cmd_v), .cmd_byte_q(cmd_b));
  mmel_host #(.BIT_CYC(BC)) mmel_host_inst (.clk(clk), .line(line), .pull_low(pull_low));
  // Sampled mid-cycle so the pulse has settled
  always @(negedge clk) begin
    if (cmd_v === 1'b1) begin
      n_cmd++;
      last_cmd = cmd_b;
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Whole run needs about 4000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic enter(input logic t, input logic d, input logic bl, input logic pl, input logic sl);
    @(negedge clk);
    reset_pin_n = 1'b0;
    entry_tst = t;
    div_pin = d;
    vector_blank = bl;
    entry_pin_low = pl;
    par_low = sl;
    repeat (4) @(negedge clk);
    check("bus_clk_rst", 16'(bclk), 16'h0000);
    check("wd_rst", 16'(wd), 16'h0001);
    reset_pin_n = 1'b1;
    repeat (6) @(negedge clk);
    par_low = 1'b0;
  endtask
  task automatic bus_rate(input int exp);
    int n;
    logic p;
    n = 0;
    p = bclk;
    repeat (32) begin
      @(negedge clk);
      if (bclk === 1'b1 && p === 1'b0) n++;
      p = bclk;
    end
    check("bus_rate", n[15:0], exp[15:0]);
  endtask
  task automatic t_user();
    enter(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    check("mon_user", 16'(mon), 16'h0000);
    check("wd_user", 16'(wd), 16'h0000);
    check("rvec_user", rvec, 16'hFFFE);
    check("svec_user", svec, 16'hFFFC);
    $display("test user done");
  endtask
  task automatic t_tst();
    for (int d = 0; d < 2; d++) begin
      enter(1'b1, d[0], 1'b0, 1'b0, 1'b0);
      check("mon_tst", 16'(mon), 16'h0001);
      check("tst", 16'(tst), 16'h0001);
      check("div4", 16'(div4), 16'(d[0]));
      check("bypass", 16'(byp), 16'(!d[0]));
      check("pll_tst", 16'(pll), 16'h0000);
      check("rvec_mon", rvec, 16'hFEFE);
      check("svec_mon", svec, 16'hFEFC);
      bus_rate(d[0] ? 8 : 16);
    end
    div_pin = 1'b0;
    entry_tst = 1'b0;
    reset_tst = 1'b1;
    repeat (6) @(negedge clk);
    check("div4_held", 16'(div4), 16'h0001);
    check("wd_rtst", 16'(wd), 16'h0001);
    reset_tst = 1'b0;
    repeat (6) @(negedge clk);
    check("wd_off", 16'(wd), 16'h0000);
    $display("test voltage entry done");
  endtask
  task automatic t_link();
    logic [7:0] b;
    logic st;
    logic got;
    enter(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      // Echo ends half a bit after recv returns; host then waits two bits
      mmel_host_inst.hold_bits(1'b1, 2);
      mmel_host_inst.send_byte({i[3:0], ~i[3:0]});
      mmel_host_inst.recv(b, st, got);
      check("sec_echo", 16'(b), 16'({i[3:0], ~i[3:0]}));
      check("sec_stop", 16'(st), 16'h0001);
      check("sec_pend", 16'(sec), 16'h0000);
    end
    check("no_cmd", n_cmd[15:0], 16'h0000);
    mmel_host_inst.recv(b, st, got);
    check("ready_brk", 16'({got, st, b}), 16'h0200);
    check("sec_done", 16'(sec), 16'h0001);
    mmel_host_inst.hold_bits(1'b1, 2);
    mmel_host_inst.send_byte(8'hA5);
    mmel_host_inst.recv(b, st, got);
    check("cmd_echo", 16'(b), 16'h00A5);
    check("cmd_count", n_cmd[15:0], 16'h0001);
    check("cmd_byte", 16'(last_cmd), 16'h00A5);
    mmel_host_inst.hold_bits(1'b1, 2);
    mmel_host_inst.send_break();
    repeat (BC / 2) @(negedge clk);
    check("lead_in", 16'({ser_oe, ser_o}), 16'h0003);
    mmel_host_inst.recv(b, st, got);
    check("brk_echo", 16'({got, st, b}), 16'h0200);
    $display("test link done");
  endtask
  task automatic t_blank();
    enter(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    check("mon_blank", 16'(mon), 16'h0001);
    check("pll_blank", 16'(pll), 16'h0001);
    check("div4_blank", 16'(div4), 16'h0001);
    check("wd_blank", 16'(wd), 16'h0001);
    enter(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    check("mon_kept", 16'(mon), 16'h0001);
    check("wd_kept", 16'(wd), 16'h0001);
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    check("mon_por", 16'(mon), 16'h0000);
    enter(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    check("mon_blank2", 16'(mon), 16'h0001);
    check("pll_off", 16'(pll), 16'h0000);
    // Blank vector must be gone before the next power-on release relatches
    vector_blank = 1'b0;
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    check("mon_por2", 16'(mon), 16'h0000);
    $display("test blank entry done");
  endtask
  task automatic t_par();
    enter(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    check("style_par", 16'(style), 16'h0000);
    $display("test parallel style done");
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_user();
    t_tst();
    t_link();
    t_blank();
    t_par();
    finish_test();
  end
endmodule // tb_mmel_top
